// ===== pkg/prs_pkg.sv
package prs_pkg;

    // timing base
    localparam int CLK_HZ = 40_000_000;
    localparam int REF_CLK_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;

    // phy reset hold and quiet interval, in milliseconds
    localparam int PHY_RST_HOLD_MS = 10;
    localparam int PHY_QUIET_MS = 5;

    // least times round up to whole cycles
    localparam int PHY_RST_HOLD_CYCLES = (PHY_RST_HOLD_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
    localparam int PHY_QUIET_CYCLES = (PHY_QUIET_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;

    // phy reset pin levels and idle levels of the transmit pins
    localparam logic PHY_RST_N_ACTIVE = 1'h0;
    localparam logic PHY_RST_N_RELEASED = 1'h1;
    localparam logic [3:0] NIBBLE_IDLE = 4'h0;
    localparam logic [7:0] BYTE_IDLE = 8'h0;
    localparam logic PIN_IDLE = 1'h0;

    // status levels and reset values
    localparam logic PHY_NOT_READY = 1'h0;
    localparam logic PHY_IS_READY = 1'h1;
    localparam logic STRAP_RESET = 1'h0;
    localparam logic STRAP_TIE_HIGH = 1'h1;

    // phy interface kinds
    typedef enum logic [1:0] {
        PRS_IF_MII,
        PRS_IF_GMII,
        PRS_IF_RGMII,
        PRS_IF_SERIAL
    } prs_if_kind_t;

    // line speeds
    typedef enum logic [1:0] {
        PRS_SPEED_10,
        PRS_SPEED_100,
        PRS_SPEED_1000
    } prs_speed_t;

    typedef struct packed {
        logic [3:0] txd;
        logic tx_en;
        logic nibble_tx_error_out;
    } prs_nibble_tx_t;

    typedef struct packed {
        logic [7:0] txd;
        logic tx_en;
        logic byte_tx_error_out;
        logic gtx_clk;
    } prs_byte_tx_t;

    typedef struct packed {
        logic [3:0] txd;
        logic tx_ctl;
        logic txc;
    } prs_ddr_tx_t;

    typedef struct packed {
        logic txp;
        logic txn;
    } prs_serial_tx_t;

    typedef struct packed {
        prs_nibble_tx_t nibble;
        prs_byte_tx_t bytes;
        prs_ddr_tx_t ddr;
        prs_serial_tx_t serial;
    } prs_tx_pins_t;

    localparam prs_tx_pins_t TX_PINS_IDLE = '{
        nibble: '{txd: NIBBLE_IDLE, tx_en: PIN_IDLE, nibble_tx_error_out: PIN_IDLE},
        bytes: '{txd: BYTE_IDLE, tx_en: PIN_IDLE, byte_tx_error_out: PIN_IDLE, gtx_clk: PIN_IDLE},
        ddr: '{txd: NIBBLE_IDLE, tx_ctl: PIN_IDLE, txc: PIN_IDLE},
        serial: '{txp: PIN_IDLE, txn: PIN_IDLE}
    };

endpackage

// ===== src/prs_tx_idle.sv
`timescale 1ns/1ps

module prs_tx_idle
    import prs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // force idle levels
    input wire logic hold_idle,
    // transmit values from the mac side
    input wire prs_tx_pins_t tx_in,
    // registered transmit pins
    output prs_tx_pins_t tx_out
);

    prs_tx_pins_t tx_r;
    prs_tx_pins_t tx_nxt;

    always_comb
    begin
        if (hold_idle)
        begin
            tx_nxt = TX_PINS_IDLE;
        end
        else
        begin
            tx_nxt = tx_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_r <= TX_PINS_IDLE;
        end
        else
        begin
            tx_r <= tx_nxt;
        end
    end

    assign tx_out = tx_r;

endmodule

// ===== src/prs_seq.sv
`timescale 1ns/1ps

// Summary of operation
// - phy reset output held low 10 ms after power-up.
// - every subsystem reset reasserts phy reset and holds it 10 ms.
// - no phy management access starts within 5 ms after reset release.
// - phy reset output comes out of reset low.
// - hold and quiet intervals are timed from the 40 MHz system clock (CLK_HZ), not the reference clock.
// - nibble transmit data, enable and error idle low at reset.
// - byte transmit data, enable, error and forwarded clock idle low at reset.
// - ddr transmit data, control and clock idle low at reset.
// - serial transmit positive and negative outputs low at reset.
// - byte mode at 10/100 clocks transmit from the phy transmit clock.
module prs_seq
    import prs_pkg::*;
#(
    parameter int HOLD_CYCLES = PHY_RST_HOLD_CYCLES,
    parameter int QUIET_CYCLES = PHY_QUIET_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // configuration straps
    input wire prs_if_kind_t if_kind,
    input wire prs_speed_t line_speed,
    input wire logic signal_detect,
    input wire logic low_speed_clk_en,
    // management gating
    input wire logic mgmt_req,
    output logic mgmt_req_ok,
    // phy control
    output logic phy_rst_n,
    output logic phy_ready,
    // transmit clock source select
    output logic tx_clk_from_phy,
    // strap status
    output logic tx_slot_enable,
    output logic optical_signal_lost,
    // transmit path
    input wire prs_tx_pins_t tx_in,
    output prs_tx_pins_t tx_out
);

    localparam int CNT_MAX = (HOLD_CYCLES > QUIET_CYCLES) ? HOLD_CYCLES : QUIET_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(QUIET_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_QUIET,
        ST_READY
    } prs_state_t;

    // low-speed byte mode decode, used for clock select and enable
    function automatic logic is_byte_low_speed(input prs_if_kind_t kind, input prs_speed_t spd);
        is_byte_low_speed = (kind == PRS_IF_GMII) && (spd != PRS_SPEED_1000);
    endfunction

    // serial link kind, where loss of light means something
    function automatic logic is_serial_link(input prs_if_kind_t kind);
        is_serial_link = (kind == PRS_IF_SERIAL);
    endfunction

    // end of a timed interval, shared by hold and quiet
    function automatic logic count_done(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] last);
        count_done = (cnt == last);
    endfunction

    // sequencer state
    prs_state_t state_r;
    prs_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic phy_rst_n_r;
    logic phy_rst_n_nxt;
    logic ready_r;
    logic ready_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        phy_rst_n_nxt = phy_rst_n_r;
        ready_nxt = ready_r;
        case (state_r)
            // phy held in reset for the hold interval
            ST_HOLD:
            begin
                phy_rst_n_nxt = PHY_RST_N_ACTIVE;
                ready_nxt = PHY_NOT_READY;
                if (count_done(cnt_r, HOLD_LAST))
                begin
                    state_nxt = ST_QUIET;
                    cnt_nxt = CNT_ZERO;
                    phy_rst_n_nxt = PHY_RST_N_RELEASED;
                end
                else
                begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            // phy released, accesses still refused
            ST_QUIET:
            begin
                phy_rst_n_nxt = PHY_RST_N_RELEASED;
                ready_nxt = PHY_NOT_READY;
                if (count_done(cnt_r, QUIET_LAST))
                begin
                    state_nxt = ST_READY;
                    cnt_nxt = CNT_ZERO;
                    ready_nxt = PHY_IS_READY;
                end
                else
                begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            // phy usable until the next subsystem reset
            ST_READY:
            begin
                cnt_nxt = CNT_ZERO;
                ready_nxt = PHY_IS_READY;
                phy_rst_n_nxt = PHY_RST_N_RELEASED;
            end
            default:
            begin
                state_nxt = ST_HOLD;
                cnt_nxt = CNT_ZERO;
                phy_rst_n_nxt = PHY_RST_N_ACTIVE;
                ready_nxt = PHY_NOT_READY;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= ST_HOLD;
            cnt_r <= CNT_ZERO;
            phy_rst_n_r <= PHY_RST_N_ACTIVE;
            ready_r <= PHY_NOT_READY;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            phy_rst_n_r <= phy_rst_n_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign phy_rst_n = phy_rst_n_r;
    assign phy_ready = ready_r;
    // management requests pass only once the phy is ready
    assign mgmt_req_ok = mgmt_req & ready_r;

    // clock source and strap state
    logic clk_from_phy_r;
    logic clk_from_phy_nxt;
    logic slot_en_r;
    logic slot_en_nxt;
    logic sig_lost_r;
    logic sig_lost_nxt;
    logic byte_low_speed;

    assign byte_low_speed = is_byte_low_speed(if_kind, line_speed);

    always_comb
    begin
        clk_from_phy_nxt = byte_low_speed;
        // pcs enable matters only in low-speed byte mode, strap high otherwise
        if (byte_low_speed)
        begin
            slot_en_nxt = low_speed_clk_en;
        end
        else
        begin
            slot_en_nxt = STRAP_TIE_HIGH;
        end
        // loss of light only counts on the serial link
        sig_lost_nxt = is_serial_link(if_kind) && !signal_detect;
    end

    // straps follow their pins one cycle late
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            clk_from_phy_r <= STRAP_RESET;
            slot_en_r <= STRAP_RESET;
            sig_lost_r <= STRAP_RESET;
        end
        else
        begin
            clk_from_phy_r <= clk_from_phy_nxt;
            slot_en_r <= slot_en_nxt;
            sig_lost_r <= sig_lost_nxt;
        end
    end

    assign tx_clk_from_phy = clk_from_phy_r;
    assign tx_slot_enable = slot_en_r;
    assign optical_signal_lost = sig_lost_r;

    // transmit pins idle while the phy is held in reset
    logic tx_hold;

    assign tx_hold = (state_r == ST_HOLD);

    prs_tx_idle u_tx_idle (
        .clk(clk),
        .srst(srst),
        .hold_idle(tx_hold),
        .tx_in(tx_in),
        .tx_out(tx_out)
    );

endmodule

// ===== tb/prs_seq_props.sv
`timescale 1ns/1ps
module prs_seq_props
    import prs_pkg::*;
#(
    parameter int HOLD_CYCLES = 20,
    parameter int QUIET_CYCLES = 10
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched ports
    input wire prs_if_kind_t if_kind,
    input wire prs_speed_t line_speed,
    input wire logic mgmt_req,
    input wire logic mgmt_req_ok,
    input wire logic phy_rst_n,
    input wire logic phy_ready,
    input wire logic tx_clk_from_phy,
    input wire prs_tx_pins_t tx_out
);
    int cnt_r;
    // edges since release, saturating
    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_r <= 0;
        else if (cnt_r < HOLD_CYCLES + QUIET_CYCLES)
            cnt_r <= cnt_r + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_hold;
        phy_rst_n == (cnt_r >= HOLD_CYCLES);
    endproperty
    a_hold: assert property (p_hold) else $error("reset level wrong");
    property p_ready;
        phy_ready == (cnt_r >= HOLD_CYCLES + QUIET_CYCLES);
    endproperty
    a_ready: assert property (p_ready) else $error("ready wrong");
    property p_start;
        $fell(srst) |-> !phy_rst_n && !phy_ready && tx_out == TX_PINS_IDLE;
    endproperty
    a_start: assert property (p_start) else $error("bad state after reset");
    property p_mgmt;
        mgmt_req_ok == (mgmt_req && phy_ready);
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("access gate wrong");
    property p_nib;
        !phy_rst_n |=> tx_out.nibble == TX_PINS_IDLE.nibble;
    endproperty
    a_nib: assert property (p_nib) else $error("nibble not idle");
    property p_byte;
        !phy_rst_n |=> tx_out.bytes == TX_PINS_IDLE.bytes;
    endproperty
    a_byte: assert property (p_byte) else $error("byte not idle");
    property p_ddr;
        !phy_rst_n |=> tx_out.ddr == TX_PINS_IDLE.ddr;
    endproperty
    a_ddr: assert property (p_ddr) else $error("ddr not idle");
    property p_ser;
        !phy_rst_n |=> tx_out.serial == TX_PINS_IDLE.serial;
    endproperty
    a_ser: assert property (p_ser) else $error("serial not idle");
    property p_src;
        !$past(srst) |-> tx_clk_from_phy == ($past(if_kind) == PRS_IF_GMII && $past(line_speed) != PRS_SPEED_1000);
    endproperty
    a_src: assert property (p_src) else $error("clock source wrong");
endmodule

bind prs_seq prs_seq_props #(.HOLD_CYCLES(HOLD_CYCLES), .QUIET_CYCLES(QUIET_CYCLES)) prs_seq_props_i (.clk, .srst,
    .if_kind, .line_speed, .mgmt_req, .mgmt_req_ok, .phy_rst_n, .phy_ready, .tx_clk_from_phy, .tx_out);

// ===== tb/prs_phy_model.sv
`timescale 1ns/1ps
module prs_phy_model
    import prs_pkg::*;
(
    // clock and mode
    input wire logic clk,
    input wire prs_if_kind_t if_kind,
    input wire prs_speed_t line_speed,
    // straps toward the block
    output logic signal_detect = 1'h1,
    output logic low_speed_clk_en = 1'h1
);
    logic [3:0] tick_r = 4'h0;
    always @(posedge clk)
    begin
        tick_r <= tick_r + 4'h1;
        signal_detect <= (if_kind == PRS_IF_SERIAL) ? (tick_r[1:0] != 2'h3) : 1'h1;
        low_speed_clk_en <= (if_kind == PRS_IF_GMII && line_speed != PRS_SPEED_1000) ? tick_r[0] : 1'h1;
    end
endmodule

// ===== tb/prs_seq_tb_top.sv
`timescale 1ns/1ps
module prs_seq_tb_top
    import prs_pkg::*;
;
    localparam int HOLD = 20;
    localparam int QUIET = 10;
    typedef struct packed {
        logic rst_n;
        logic rdy;
        logic ok;
        logic src;
        logic slot;
        logic lost;
        prs_tx_pins_t tx;
    } prs_exp_t;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic mgmt_req = 1'h0;
    prs_if_kind_t if_kind = PRS_IF_MII;
    prs_speed_t line_speed = PRS_SPEED_10;
    prs_tx_pins_t tx_in = '0;
    prs_tx_pins_t tx_out;
    prs_tx_pins_t v_prev;
    logic signal_detect, low_speed_clk_en, mgmt_req_ok, phy_rst_n, phy_ready;
    logic tx_clk_from_phy, tx_slot_enable, optical_signal_lost;
    prs_exp_t exp_q[$];
    prs_exp_t e;
    int fails = 0;
    int compares = 0;
    int seed = 32'ha499;
    int k;
    always #12.5 clk = ~clk;
    prs_seq #(.HOLD_CYCLES(HOLD), .QUIET_CYCLES(QUIET)) prs_seq_i (.clk, .srst, .if_kind, .line_speed,
        .signal_detect, .low_speed_clk_en, .mgmt_req, .mgmt_req_ok, .phy_rst_n, .phy_ready, .tx_clk_from_phy,
        .tx_slot_enable, .optical_signal_lost, .tx_in, .tx_out);
    prs_phy_model prs_phy_model_i (.clk, .if_kind, .line_speed, .signal_detect, .low_speed_clk_en);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_reset();
        srst <= 1'h1;
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        k = 0;
    endtask
    // drive random traffic and note what each edge must yield
    task automatic run(input int n);
        prs_exp_t x;
        logic [31:0] r;
        repeat (n)
        begin
            @(posedge clk);
            k++;
            r = $random(seed);
            x.rst_n = (k >= HOLD);
            x.rdy = (k >= HOLD + QUIET);
            x.ok = r[31] && x.rdy;
            x.src = (if_kind == PRS_IF_GMII && line_speed != PRS_SPEED_1000);
            x.slot = x.src ? low_speed_clk_en : 1'h1;
            x.lost = (if_kind == PRS_IF_SERIAL) && !signal_detect;
            x.tx = (k <= HOLD) ? TX_PINS_IDLE : v_prev;
            exp_q.push_back(x);
            v_prev = r[$bits(prs_tx_pins_t)-1:0];
            tx_in <= r[$bits(prs_tx_pins_t)-1:0];
            mgmt_req <= r[31];
            if_kind <= prs_if_kind_t'(r[30:29]);
            line_speed <= prs_speed_t'(2'(k % 3));
        end
        $display("run of %0d cycles done", n);
    endtask
    always @(posedge clk)
    begin
        #1;
        if (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check("phy_rst_n", 32'(phy_rst_n), 32'(e.rst_n));
            check("phy_ready", 32'(phy_ready), 32'(e.rdy));
            check("mgmt_req_ok", 32'(mgmt_req_ok), 32'(e.ok));
            check("tx_clk_from_phy", 32'(tx_clk_from_phy), 32'(e.src));
            check("tx_slot_enable", 32'(tx_slot_enable), 32'(e.slot));
            check("optical_signal_lost", 32'(optical_signal_lost), 32'(e.lost));
            check("tx_out", 32'(tx_out), 32'(e.tx));
        end
    end
    initial
    begin
        do_reset();
        // reset again inside the quiet interval
        run(HOLD + 5);
        do_reset();
        run(HOLD + QUIET + 60);
        #2;
        stop_test();
    end
endmodule
